/* bench/pss_link_props.sv */
// Purpose: Link checks between supervisor and host
// Assumes: Single clock, reset active high
// Notes: Status is {shut,warn,osc,aux,adj,filt,bus,normal}
`timescale 1ns/1ps
module pss_link_props (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic host_reset_n,
  input wire logic save_warning_n,
  input wire pss_pkg::clk_rate_type host_clock_rate,
  input wire logic host_clock_out_enable,
  input wire logic [7:0] status,
  input wire logic shutdown_flag_read,
  input wire logic transmit_marker_out,
  input wire logic marker_enable
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // ==========
  // Assertions
  a_clock_off_disabled: assert property (!host_clock_out_enable [*3] |->
    host_clock_rate == pss_pkg::CLK_OFF) else $error("host clock runs while disabled");
  a_normal_fast_rate: assert property ((status[0] && host_clock_out_enable) [*3] |->
    host_clock_rate inside {pss_pkg::CLK_8M, pss_pkg::CLK_16M}) else $error("slow clock");
  a_reset_not_normal: assert property (!host_reset_n [*2] |-> !status[0])
    else $error("normal with host reset low");
  a_entry_save_high: assert property ($rose(status[0]) |-> ##[0:1] save_warning_n)
    else $error("save warning kept low");
  a_warn_save_low: assert property (status[6] [*3] |-> !save_warning_n)
    else $error("save warning high in thermal warning");
  a_entry_all_good: assert property ($rose(status[0]) |-> status[6:1] == 6'b011111)
    else $error("normal entered with a bad flag");
  a_shutdown_clear_read: assert property ($fell(status[7]) |->
    $past(shutdown_flag_read) || $past(shutdown_flag_read, 2))
    else $error("shutdown flag cleared unread");
  a_shutdown_holds_reset: assert property ($rose(status[7]) |-> ##[0:3] !host_reset_n)
    else $error("shutdown without host reset");
  a_marker_disabled: assert property (!marker_enable [*3] |-> !transmit_marker_out)
    else $error("marker high while disabled");
  c_normal: cover property ($rose(status[0]));
  c_shutdown_read: cover property ($fell(status[7]));
  c_marker: cover property ($rose(transmit_marker_out));
endmodule : pss_link_props

/* bench/tb_power_state_supervisor.sv */
// Purpose: Bench for supervisor and host ends over the link
// Assumes: Counts shortened by parameters
// Notes: Rate pin and strap drawn from a fixed seed
`timescale 1ns/1ps
module tb_power_state_supervisor;
  localparam int SD = 20;
  localparam int BT = 8;
  logic clk = 1'b0, rst = 1'b1, por = 1'b1, bg = 1'b0, b20 = 1'b1, f10 = 1'b0, fs = 1'b0;
  logic f14 = 1'b1, f12 = 1'b1, fr = 1'b0, ar = 1'b0, xr = 1'b0, warm = 1'b0, hot = 1'b0;
  logic ok = 1'b0, rs = 1'b0, ss = 1'b0, txs = 1'b0, txi = 1'b0, txd = 1'b0, col = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, e, mt, pready, perr, rails, busa, txst, osc;
  logic [7:0] pa = 8'h00;
  logic [7:0] slim;
  logic [10:0] slope;
  logic [31:0] pd = 32'h0, prd, r;
  pss_pkg::pwr_state_type st;
  int err_total = 0, samples_checked = 0, n, m;
  pss_if link();
  power_state_supervisor #(.SAVE_DELAY(SD), .OSC_START(20), .BUS_FILTER(4), .BIT_TIME(BT))
    u_power_state_supervisor (.I_CLK(clk), .I_SYS_RST(rst), .I_POR(por),
    .I_BUS_VOLTAGE_GOOD(bg), .I_BUS_BELOW_20V(b20), .I_FILT_ABOVE_10V(f10),
    .I_FILTERED_SUPPLY(fs), .I_FILT_BELOW_14V(f14), .I_FILT_BELOW_12V(f12), .I_FIXED_RAIL(fr),
    .I_ADJUSTABLE_RAIL(ar), .I_AUXILIARY_RAIL(xr), .I_THERMAL_WARNING(warm),
    .I_THERMAL_SHUTDOWN(hot), .I_OSC_OK(ok), .I_CLOCK_SOURCE_SELECT(1'b0),
    .I_HOST_CLOCK_RATE_SELECT(rs), .I_STRAP_STRONG(ss), .I_TX_SCHEDULED(txs),
    .I_TX_IMMEDIATE(txi), .I_TX_DONE(txd), .I_COLLISION(col), .link(link.device),
    .O_OSC_ON(osc), .O_RAILS_ON(rails), .O_BUS_ACTIVE(busa), .O_TX_START(txst),
    .O_SLOPE_LIMIT(slope), .O_START_LIMIT(slim), .O_STATE(st));
  pss_host u_pss_host (.I_CLK(clk), .I_SYS_RST(rst), .link(link.host), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pd), .O_PRDATA(prd),
    .O_PREADY(pready), .O_PSLVERR(perr), .O_HOST_MAY_TALK(mt));
  pss_link_props u_pss_link_props (.I_CLK(clk), .I_SYS_RST(rst),
    .host_reset_n(link.host_reset_n), .save_warning_n(link.save_warning_n),
    .host_clock_rate(link.host_clock_rate), .host_clock_out_enable(link.host_clock_out_enable),
    .status(link.status), .shutdown_flag_read(link.shutdown_flag_read),
    .transmit_marker_out(link.transmit_marker_out), .marker_enable(link.marker_enable));
  // ==========
  // Tasks
  initial forever #50 clk = ~clk;
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int c);
    repeat (c) @(posedge clk);
  endtask : step
  task automatic wst(input pss_pkg::pwr_state_type s);
    while (st !== s) @(posedge clk);
    @(posedge clk);
  endtask : wst
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  function automatic logic [1:0] fast(input logic sel);
    return sel ? pss_pkg::CLK_16M : pss_pkg::CLK_8M;
  endfunction : fast
  function automatic logic [18:0] lim(input logic s);
    return s ? {11'h3e8, 8'h3c} : {11'h1f4, 8'h1e};
  endfunction : lim
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // ==========
  // Stimulus
  initial begin
    void'($urandom(32'h6cd0));
    step(4);
    rst <= 1'b0;
    rs <= 1'($urandom);
    step(3);
    chk({st, link.host_reset_n}, {pss_pkg::ST_RESET, 1'b0});
    por <= 1'b0;
    f10 <= 1'b1;
    f12 <= 1'b0;
    fr <= 1'b1;
    wst(pss_pkg::ST_STANDBY);
    chk({link.host_reset_n, mt, link.host_clock_rate}, {2'b11, pss_pkg::CLK_4M});
    chk({busa, link.save_warning_n, osc}, 3'b000);
    bg <= 1'b1;
    b20 <= 1'b0;
    fs <= 1'b1;
    f14 <= 1'b0;
    ar <= 1'b1;
    xr <= 1'b1;
    ok <= 1'b1;
    wst(pss_pkg::ST_NORMAL);
    chk({link.host_clock_rate, link.save_warning_n, busa}, {fast(rs), 2'b11});
    apb(1'b0, pss_pkg::REG_STATUS, 32'h0);
    chk({e, r[30:0]}, {1'b0, 31'h3f});
    apb(1'b0, pss_pkg::REG_PROFILE, 32'h0);
    chk(r, {27'h0, 2'b11, fast(rs), 1'b0});
    apb(1'b0, 8'h0c, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, pss_pkg::REG_CTRL, 32'h0);
    step(4);
    chk(link.host_clock_rate, pss_pkg::CLK_OFF);
    apb(1'b1, pss_pkg::REG_CTRL, 32'h9);
    step(4);
    chk(link.host_clock_rate, fast(rs));
    for (int i = 0; i < 6; i++) begin
      ss <= (i < 2) ? i[0] : 1'($urandom);
      step(2);
      chk({slope, slim}, lim(ss));
    end
    $display("test power up and normal done");
    txs <= 1'b1;
    m = 0;
    for (n = 0; n < 40 && txst !== 1'b1; n++) begin
      @(posedge clk);
      m += int'(link.transmit_marker_out);
    end
    chk(m >= BT - 1 && m <= BT + 1, 1'b1);
    txd <= 1'b1;
    txs <= 1'b0;
    @(posedge clk);
    txd <= 1'b0;
    step(2);
    chk(link.transmit_marker_out, 1'b0);
    txi <= 1'b1;
    for (n = 0; n < 40 && txst !== 1'b1; n++) begin
      @(posedge clk);
    end
    chk(n < 5, 1'b1);
    col <= 1'b1;
    txi <= 1'b0;
    @(posedge clk);
    col <= 1'b0;
    step(2);
    chk(link.transmit_marker_out, 1'b0);
    $display("test marker done");
    bg <= 1'b0;
    wst(pss_pkg::ST_STANDBY);
    chk({link.save_warning_n, rails, link.host_clock_rate}, {2'b01, fast(rs)});
    bg <= 1'b1;
    wst(pss_pkg::ST_NORMAL);
    ok <= 1'b0;
    wst(pss_pkg::ST_STANDBY);
    chk(link.host_clock_rate, pss_pkg::CLK_4M);
    ok <= 1'b1;
    wst(pss_pkg::ST_NORMAL);
    ar <= 1'b0;
    wst(pss_pkg::ST_STANDBY);
    chk({rails, link.host_clock_rate}, {1'b0, fast(rs)});
    ar <= 1'b1;
    wst(pss_pkg::ST_NORMAL);
    f14 <= 1'b1;
    step(4);
    chk(link.save_warning_n, 1'b0);
    f14 <= 1'b0;
    wst(pss_pkg::ST_NORMAL);
    b20 <= 1'b1;
    step(SD - 4);
    chk(link.save_warning_n, 1'b1);
    step(8);
    chk(link.save_warning_n, 1'b0);
    b20 <= 1'b0;
    wst(pss_pkg::ST_NORMAL);
    f12 <= 1'b1;
    step(4);
    chk({link.host_reset_n, mt}, 2'b00);
    f12 <= 1'b0;
    wst(pss_pkg::ST_NORMAL);
    $display("test supply faults done");
    warm <= 1'b1;
    step(4);
    apb(1'b0, pss_pkg::REG_STATUS, 32'h0);
    chk({link.save_warning_n, r[30:0]}, {1'b0, 31'h7e});
    warm <= 1'b0;
    wst(pss_pkg::ST_NORMAL);
    apb(1'b0, pss_pkg::REG_STATUS, 32'h0);
    chk(r, 32'h3f);
    hot <= 1'b1;
    wst(pss_pkg::ST_RESET);
    apb(1'b0, pss_pkg::REG_STATUS, 32'h0);
    chk({e, link.host_reset_n, rails, st}, {3'b100, pss_pkg::ST_RESET});
    hot <= 1'b0;
    wst(pss_pkg::ST_STANDBY);
    chk(mt, 1'b1);
    wst(pss_pkg::ST_NORMAL);
    apb(1'b0, pss_pkg::REG_STATUS, 32'h0);
    chk(r, 32'hbf);
    apb(1'b0, pss_pkg::REG_STATUS, 32'h0);
    chk(r, 32'h3f);
    por <= 1'b1;
    step(4);
    chk({st, link.host_reset_n}, {pss_pkg::ST_RESET, 1'b0});
    $display("test thermal and power-on done");
    tally_and_finish();
  end
endmodule : tb_power_state_supervisor

/* include/pss_if.sv */
// Purpose: Link between supervisor device and host controller
// Assumes: One clock shared by both ends
// Notes: Open-drain outputs carry output and enable
`timescale 1ns/1ps
interface pss_if;
  logic host_reset_n_o;
  logic host_reset_n_oe;
  logic save_warning_n_o;
  logic save_warning_n_oe;
  logic host_clock_out;
  pss_pkg::clk_rate_type host_clock_rate;
  logic host_clock_out_enable;
  logic [7:0] status;
  logic shutdown_flag_read;
  logic transmit_marker_out;
  logic marker_enable;
  logic host_reset_n;
  logic save_warning_n;
  assign host_reset_n = host_reset_n_oe ? host_reset_n_o : 1'b1;
  assign save_warning_n = save_warning_n_oe ? save_warning_n_o : 1'b1;
  modport device (
    output host_reset_n_o, host_reset_n_oe, save_warning_n_o, save_warning_n_oe,
    output host_clock_out, host_clock_rate, status, transmit_marker_out,
    input host_clock_out_enable, shutdown_flag_read, marker_enable
  );
  modport host (
    input host_reset_n, save_warning_n, host_clock_out, host_clock_rate, status,
    input transmit_marker_out,
    output host_clock_out_enable, shutdown_flag_read, marker_enable
  );
endinterface : pss_if

/* include/pss_pkg.sv */
// Purpose: Shared constants and types for the power state supervisor
// Assumes: 10 MHz system clock
// Notes: Save, oscillator and filter times given in us, cycle counts derived; bit time and trim read given in cycles
package pss_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int SAVE_DELAY_US = 2000;
  localparam int SAVE_DELAY_CYC = (SAVE_DELAY_US * (CLK_HZ / 1000000));
  localparam int OSC_START_US = 2000;
  localparam int OSC_START_CYC = (OSC_START_US * (CLK_HZ / 1000000));
  localparam int BUS_FILTER_US = 10;
  localparam int BUS_FILTER_CYC = (BUS_FILTER_US * (CLK_HZ / 1000000));
  localparam int BIT_TIME_CYC = 1042;
  localparam int TRIM_READ_CYC = 16;
  localparam logic [1:0] ST_RESET_V = 2'b00;
  localparam logic [1:0] ST_STARTUP_V = 2'b01;
  localparam logic [1:0] ST_STANDBY_V = 2'b11;
  localparam logic [1:0] ST_NORMAL_V = 2'b10;
  // Slope limit in uA/ms and start-up current limit in mA
  localparam logic [10:0] SLOPE_LOW_UA_MS = 11'h1f4;
  localparam logic [10:0] SLOPE_HIGH_UA_MS = 11'h3e8;
  localparam logic [7:0] START_LIM_LOW_MA = 8'h1e;
  localparam logic [7:0] START_LIM_HIGH_MA = 8'h3c;
  localparam int MARKER_ENABLE_BIT = 3;
  // Host register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PROFILE = 8'h08;
  localparam logic [7:0] CTRL_RESET_V = 8'h09;
  localparam int CTRL_CLK_EN_BIT = 0;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_STARTUP = 2'b01,
    ST_STANDBY = 2'b11,
    ST_NORMAL = 2'b10
  } pwr_state_type;
  typedef enum logic [1:0] {
    CLK_OFF = 2'b00,
    CLK_4M = 2'b01,
    CLK_8M = 2'b10,
    CLK_16M = 2'b11
  } clk_rate_type;
endpackage : pss_pkg

/* rtl/power_state_supervisor.sv */
// Purpose: Power state sequencing, host reset, save warning, host clock
// Assumes: Comparator flags are asynchronous levels
// Notes: Host clock output toggles at half the system clock whenever the rate is not off
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Function
// - Stand-By after power-up gives 4 MHz clock
// - Normal gives 8 or 16 MHz per pin
// - Host clears enable; clock output stops
// - Normal to Stand-By keeps rate unless oscillator
// - Weak strap: 0.5 mA/ms, 30 mA
// - Strong strap: 1 mA/ms, 60 mA
// - Marker rises bit before, falls end/collision
// - Idle or response: transmit right after marker
// - Reset low on low bus, converter, shutdown
// - Save warning: filtered 14 V, bus 2 ms
// - Reset low below filtered 12 V
// - Supervisor outputs readable as status
// - Stand-By from Start-Up: oscillator off, 4 MHz
// - Stand-By from Normal keeps rails unless rail fault
// - Save warning low on thermal warning
// - Host acts on thermal warning
// - Shutdown enters Reset, latches flag, stops supplies
// - Cool gives Start-Up then Stand-By, release reset
// - Normal only when cool and voltages good
// - Warning clears live; shutdown clears on read
// - Long low bus drops Normal, save low
module power_state_supervisor #(
  parameter int SAVE_DELAY = pss_pkg::SAVE_DELAY_CYC,
  parameter int OSC_START = pss_pkg::OSC_START_CYC,
  parameter int BUS_FILTER = pss_pkg::BUS_FILTER_CYC,
  parameter int BIT_TIME = pss_pkg::BIT_TIME_CYC
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_POR,
  input wire logic I_BUS_VOLTAGE_GOOD,
  input wire logic I_BUS_BELOW_20V,
  input wire logic I_FILT_ABOVE_10V,
  input wire logic I_FILTERED_SUPPLY,
  input wire logic I_FILT_BELOW_14V,
  input wire logic I_FILT_BELOW_12V,
  input wire logic I_FIXED_RAIL,
  input wire logic I_ADJUSTABLE_RAIL,
  input wire logic I_AUXILIARY_RAIL,
  input wire logic I_THERMAL_WARNING,
  input wire logic I_THERMAL_SHUTDOWN,
  input wire logic I_OSC_OK,
  input wire logic I_CLOCK_SOURCE_SELECT,
  input wire logic I_HOST_CLOCK_RATE_SELECT,
  input wire logic I_STRAP_STRONG,
  input wire logic I_TX_SCHEDULED,
  input wire logic I_TX_IMMEDIATE,
  input wire logic I_TX_DONE,
  input wire logic I_COLLISION,
  pss_if.device link,
  output logic O_OSC_ON,
  output logic O_RAILS_ON,
  output logic O_BUS_ACTIVE,
  output logic O_TX_START,
  output logic [10:0] O_SLOPE_LIMIT,
  output logic [7:0] O_START_LIMIT,
  output pss_pkg::pwr_state_type O_STATE
);
  // ==========================================================
  // Synchronisers
  localparam int NF = 14;
  logic [NF-1:0] raw;
  logic [NF-1:0] s1_q;
  logic [NF-1:0] s2_q;
  assign raw = {I_POR, I_BUS_VOLTAGE_GOOD, I_BUS_BELOW_20V, I_FILT_ABOVE_10V,
    I_FILTERED_SUPPLY, I_FILT_BELOW_14V, I_FILT_BELOW_12V, I_FIXED_RAIL,
    I_ADJUSTABLE_RAIL, I_AUXILIARY_RAIL, I_THERMAL_WARNING, I_THERMAL_SHUTDOWN,
    I_OSC_OK, I_HOST_CLOCK_RATE_SELECT};
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  wire por = s2_q[13];
  wire bus_ok_raw = s2_q[12];
  wire bus_lo20 = s2_q[11];
  wire filt10 = s2_q[10];
  wire filt_ok = s2_q[9];
  wire filt_lo14 = s2_q[8];
  wire filt_lo12 = s2_q[7];
  wire fixed_ok = s2_q[6];
  wire adj_ok = s2_q[5];
  wire v20 = s2_q[4];
  wire warn_hot = s2_q[3];
  wire shut_hot = s2_q[2];
  wire osc_ok = s2_q[1];
  wire rate_hi = s2_q[0];
  // ==========================================================
  // Filters and timers
  logic bus_low_long;
  logic bus_save_done;
  logic trim_done;
  logic osc_wait_done;
  logic lead_done;
  pss_pkg::pwr_state_type st_q;
  pss_pkg::pwr_state_type st_d;
  logic bus_ok_q;
  logic shut_flag_q;
  logic from_normal_q;
  logic osc_fault_q;
  logic rail_fault_q;
  logic marker_q;
  pss_delay #(.COUNT(BUS_FILTER)) u_busf (.i_clk(I_CLK), .i_rst(I_SYS_RST),
    .i_cond(!bus_ok_raw), .o_done(bus_low_long));
  pss_delay #(.COUNT(SAVE_DELAY)) u_save (.i_clk(I_CLK), .i_rst(I_SYS_RST),
    .i_cond(bus_lo20), .o_done(bus_save_done));
  pss_delay #(.COUNT(pss_pkg::TRIM_READ_CYC)) u_trim (.i_clk(I_CLK), .i_rst(I_SYS_RST),
    .i_cond(st_q == pss_pkg::ST_STARTUP && fixed_ok), .o_done(trim_done));
  pss_delay #(.COUNT(OSC_START)) u_osc (.i_clk(I_CLK), .i_rst(I_SYS_RST),
    .i_cond(st_q == pss_pkg::ST_STANDBY), .o_done(osc_wait_done));
  pss_delay #(.COUNT(BIT_TIME)) u_lead (.i_clk(I_CLK), .i_rst(I_SYS_RST),
    .i_cond(marker_q && I_TX_SCHEDULED), .o_done(lead_done));
  // ==========================================================
  // State machine
  wire osc_run = (st_q == pss_pkg::ST_NORMAL) || (st_q == pss_pkg::ST_STANDBY &&
    ((from_normal_q && !osc_fault_q) || osc_wait_done));
  wire all_good = bus_ok_q && filt_ok && adj_ok && v20 && !warn_hot && osc_ok &&
    osc_run;
  wire to_reset = por || shut_hot || !filt10 || filt_lo12;
  wire bus_ok_set = bus_ok_raw && st_q != pss_pkg::ST_RESET;
  always_comb begin
    st_d = st_q;
    case (st_q)
      pss_pkg::ST_RESET: begin
        if (!to_reset) begin
          st_d = pss_pkg::ST_STARTUP;
        end
      end
      pss_pkg::ST_STARTUP: begin
        if (to_reset) begin
          st_d = pss_pkg::ST_RESET;
        end else if (trim_done) begin
          st_d = pss_pkg::ST_STANDBY;
        end
      end
      pss_pkg::ST_STANDBY: begin
        if (to_reset) begin
          st_d = pss_pkg::ST_RESET;
        end else if (all_good) begin
          st_d = pss_pkg::ST_NORMAL;
        end
      end
      pss_pkg::ST_NORMAL: begin
        if (to_reset) begin
          st_d = pss_pkg::ST_RESET;
        end else if (!all_good || bus_low_long) begin
          st_d = pss_pkg::ST_STANDBY;
        end
      end
      default: begin
        st_d = pss_pkg::ST_RESET;
      end
    endcase
  end
  wire leave_normal = st_q == pss_pkg::ST_NORMAL && st_d == pss_pkg::ST_STANDBY;
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      st_q <= pss_pkg::ST_RESET;
      from_normal_q <= 1'b0;
      osc_fault_q <= 1'b0;
      rail_fault_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (leave_normal) begin
        from_normal_q <= 1'b1;
        osc_fault_q <= !osc_ok;
        rail_fault_q <= !adj_ok || !v20;
      end else if (st_d != pss_pkg::ST_STANDBY) begin
        from_normal_q <= 1'b0;
        osc_fault_q <= 1'b0;
        rail_fault_q <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Flags
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      bus_ok_q <= 1'b0;
      shut_flag_q <= 1'b0;
    end else begin
      if (bus_low_long) begin
        bus_ok_q <= 1'b0;
      end else if (bus_ok_set) begin
        bus_ok_q <= 1'b1;
      end
      if (shut_hot) begin
        shut_flag_q <= 1'b1;
      end else if (link.shutdown_flag_read) begin
        shut_flag_q <= 1'b0;
      end
    end
  end
  assign link.status = {shut_flag_q, warn_hot, osc_ok, v20, adj_ok, filt_ok, bus_ok_q,
    st_q == pss_pkg::ST_NORMAL};
  // ==========================================================
  // Host reset, save warning, clock
  wire reset_low = st_q == pss_pkg::ST_RESET || st_q == pss_pkg::ST_STARTUP;
  wire save_low = st_q != pss_pkg::ST_NORMAL || filt_lo14 || bus_save_done ||
    warn_hot;
  assign link.host_reset_n_o = 1'b0;
  assign link.host_reset_n_oe = reset_low;
  assign link.save_warning_n_o = 1'b0;
  assign link.save_warning_n_oe = save_low;
  pss_pkg::clk_rate_type rate;
  wire fast = st_q == pss_pkg::ST_NORMAL ||
    (st_q == pss_pkg::ST_STANDBY && from_normal_q && !osc_fault_q);
  assign rate = !link.host_clock_out_enable || reset_low ? pss_pkg::CLK_OFF :
    fast ? (rate_hi ? pss_pkg::CLK_16M : pss_pkg::CLK_8M) : pss_pkg::CLK_4M;
  logic clk_tgl_q;
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      clk_tgl_q <= 1'b0;
    end else begin
      clk_tgl_q <= (rate != pss_pkg::CLK_OFF) && !clk_tgl_q;
    end
  end
  assign link.host_clock_out = clk_tgl_q;
  assign link.host_clock_rate = rate;
  // ==========================================================
  // Supplies, strap, transmit marker
  assign O_OSC_ON = osc_run;
  assign O_RAILS_ON = !reset_low && filt_ok && !shut_hot &&
    !(st_q == pss_pkg::ST_STANDBY && from_normal_q && rail_fault_q);
  assign O_BUS_ACTIVE = st_q == pss_pkg::ST_NORMAL;
  assign O_SLOPE_LIMIT = I_STRAP_STRONG ? pss_pkg::SLOPE_HIGH_UA_MS : pss_pkg::SLOPE_LOW_UA_MS;
  assign O_START_LIMIT = I_STRAP_STRONG ? pss_pkg::START_LIM_HIGH_MA : pss_pkg::START_LIM_LOW_MA;
  assign O_STATE = st_q;
  wire tx_req = I_TX_SCHEDULED || I_TX_IMMEDIATE;
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      marker_q <= 1'b0;
    end else if (I_TX_DONE || I_COLLISION || !link.marker_enable) begin
      marker_q <= 1'b0;
    end else if (tx_req && O_BUS_ACTIVE) begin
      marker_q <= 1'b1;
    end
  end
  assign link.transmit_marker_out = marker_q;
  assign O_TX_START = marker_q && (I_TX_IMMEDIATE || lead_done);
  wire unused_ok = I_CLOCK_SOURCE_SELECT;
endmodule : power_state_supervisor

/* rtl/pss_delay.sv */
// Purpose: Counts a condition held for a number of cycles
// Assumes: Condition synchronous to clock
// Notes: Output high once condition held COUNT cycles
`timescale 1ns/1ps
module pss_delay #(
  parameter int COUNT = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cond,
  output logic o_done
);
  logic [23:0] cnt_q;
  logic [23:0] cnt_d;
  wire at_end = (cnt_q >= 24'(COUNT));
  assign cnt_d = !i_cond ? 24'h000000 : (at_end ? cnt_q : cnt_q + 24'h000001);
  assign o_done = i_cond && at_end;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 24'h000000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : pss_delay

/* rtl/pss_host.sv */
// Purpose: Host controller end, register file over APB
// Assumes: Zero wait state APB slave
// Notes: Any status read while host reset is high clears shutdown flag
`timescale 1ns/1ps
module pss_host (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  pss_if.host link,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_HOST_MAY_TALK
);
  // ==========================================================
  // Register file
  logic [7:0] ctrl_q;
  logic [31:0] rdata_q;
  wire acc = I_PSEL && I_PENABLE;
  wire hit_ctrl = I_PADDR == pss_pkg::REG_CTRL;
  wire hit_stat = I_PADDR == pss_pkg::REG_STATUS;
  wire hit_prof = I_PADDR == pss_pkg::REG_PROFILE;
  wire mapped = hit_ctrl || hit_stat || hit_prof;
  wire may_talk = link.host_reset_n;
  wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_q} :
    hit_stat ? {24'h000000, link.status} :
    hit_prof ? {27'h0000000, link.save_warning_n, link.host_reset_n,
      link.host_clock_rate, link.transmit_marker_out} : 32'h00000000;
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ctrl_q <= pss_pkg::CTRL_RESET_V;
    end else if (acc && I_PWRITE && hit_ctrl && may_talk) begin
      ctrl_q <= I_PWDATA[7:0];
    end
  end
  // Read data sampled in setup so it is valid in access phase
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rdata_q <= 32'h00000000;
    end else if (I_PSEL && !I_PENABLE) begin
      rdata_q <= rd_mux;
    end
  end
  assign O_PRDATA = rdata_q;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = acc && (!mapped || !may_talk);
  assign link.host_clock_out_enable = ctrl_q[pss_pkg::CTRL_CLK_EN_BIT];
  assign link.marker_enable = ctrl_q[pss_pkg::MARKER_ENABLE_BIT];
  assign link.shutdown_flag_read = acc && !I_PWRITE && hit_stat && may_talk;
  assign O_HOST_MAY_TALK = may_talk;
endmodule : pss_host
